//--- inc/dcr_pkg.sv
// Package for the device control register block.
// Assumes an APB slave with 32-bit data and one register word per offset.
package dcr_pkg;

    // Register map
    localparam logic [11:0] DEVICE_CONTROL_OFFSET = 12'h048;
    localparam logic [11:0] DEBUG_CONTROL_OFFSET = 12'h100;

    // Field positions in device_control and in the debug control word
    localparam int CORR_BIT = 0;
    localparam int NONFATAL_BIT = 1;
    localparam int FATAL_BIT = 2;
    localparam int UNSUP_BIT = 3;
    localparam int PAYLOAD_LSB = 5;
    localparam int WIDE_TAG_BIT = 8;
    localparam int SEQ_TAG_BIT = 0;

    // Reset values and the fixed supported payload code
    localparam logic [3:0] REPORT_RESET = 4'h0;
    localparam logic [2:0] PAYLOAD_RESET = 3'h0;
    localparam logic WIDE_TAG_RESET = 1'b0;
    localparam logic SEQ_TAG_RESET = 1'b0;
    localparam logic [2:0] SUPPORTED_PAYLOAD_CODE = 3'h4;

    // Payload encodings
    localparam logic [2:0] PAYLOAD_LAST_LEGAL = 3'h5;
    localparam logic [12:0] PAYLOAD_MIN_BYTES = 13'h0080;

    // Tag ranges
    localparam logic [7:0] NARROW_TAG_MAX = 8'h1f;
    localparam logic [7:0] WIDE_TAG_MAX = 8'hff;

    // Stored control fields
    typedef struct packed {
        logic wide_tag_enable;
        logic [2:0] payload_limit;
        logic unsupported_request_report_enable;
        logic fatal_report_enable;
        logic nonfatal_report_enable;
        logic correctable_report_enable;
    } dcr_ctrl_type;

endpackage : dcr_pkg

//--- logic/dcr_device_control.sv
// Device control register of a switch port, with its debug tag generator.
// Assumes an APB master on CLK; reset RST is asynchronous, active high.
`timescale 1ns/1ps

module dcr_device_control
    import dcr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TAG_ADVANCE,
    input wire logic PASS_NO_SNOOP,
    input wire logic [2:0] PASS_READ_SIZE,
    output logic CORR_REPORT_ENABLE,
    output logic NONFATAL_REPORT_ENABLE,
    output logic FATAL_REPORT_ENABLE,
    output logic UNSUP_REPORT_ENABLE,
    output logic RELAXED_ORDERING_ATTR,
    output logic FWD_NO_SNOOP,
    output logic [2:0] FWD_READ_SIZE,
    output logic [12:0] PAYLOAD_BYTES,
    output logic [2:0] SUPPORTED_PAYLOAD,
    output logic DEBUG_SEQ_TAG,
    output logic [7:0] TAG_VALUE
);

    dcr_ctrl_type ctrl;
    logic seq_tag;
    logic [7:0] tag;
    logic [12:0] payload_bytes;
    logic fwd_no_snoop;
    logic [2:0] fwd_read_size;

    // Bus phase decode
    wire access = PSEL && PENABLE;
    wire hit_ctrl = PADDR == DEVICE_CONTROL_OFFSET;
    wire hit_debug = PADDR == DEBUG_CONTROL_OFFSET;
    wire mapped = hit_ctrl || hit_debug;
    wire wr_ctrl = access && PWRITE && hit_ctrl;
    wire wr_debug = access && PWRITE && hit_debug;

    // Byte lane writes; only implemented fields take data
    wire [15:0] ctrl_word = {1'b0, 3'h0, 1'b0, 1'b0, 1'b0, ctrl.wide_tag_enable,
                             ctrl.payload_limit, 1'b0, ctrl.unsupported_request_report_enable,
                             ctrl.fatal_report_enable, ctrl.nonfatal_report_enable,
                             ctrl.correctable_report_enable};
    wire [15:0] next_word = {PSTRB[1] ? PWDATA[15:8] : ctrl_word[15:8],
                             PSTRB[0] ? PWDATA[7:0] : ctrl_word[7:0]};
    wire dcr_ctrl_type next_ctrl = '{
        wide_tag_enable: next_word[WIDE_TAG_BIT],
        payload_limit: next_word[PAYLOAD_LSB +: 3],
        unsupported_request_report_enable: next_word[UNSUP_BIT],
        fatal_report_enable: next_word[FATAL_BIT],
        nonfatal_report_enable: next_word[NONFATAL_BIT],
        correctable_report_enable: next_word[CORR_BIT]
    };
    wire next_seq_tag = PSTRB[0] ? PWDATA[SEQ_TAG_BIT] : seq_tag;

    // Effective payload size, reserved codes fall back to the minimum
    wire payload_legal = ctrl.payload_limit <= PAYLOAD_LAST_LEGAL;
    wire [12:0] next_payload_bytes = payload_legal
        ? 13'(PAYLOAD_MIN_BYTES << ctrl.payload_limit)
        : PAYLOAD_MIN_BYTES;

    // Tag range selection
    wire [7:0] tag_max = ctrl.wide_tag_enable ? WIDE_TAG_MAX : NARROW_TAG_MAX;
    wire [7:0] next_tag = (tag >= tag_max) ? 8'h00 : 8'(tag + 8'h01);

    // Read mux
    wire [31:0] read_data = hit_ctrl ? {16'h0000, ctrl_word}
                          : hit_debug ? {31'h0, seq_tag}
                          : 32'h0000_0000;

    // Register writes
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl <= '{WIDE_TAG_RESET, PAYLOAD_RESET, REPORT_RESET[3], REPORT_RESET[2],
                      REPORT_RESET[1], REPORT_RESET[0]};
            seq_tag <= SEQ_TAG_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= next_ctrl;
            if (wr_debug)
                seq_tag <= next_seq_tag;
        end
    end

    // Read data register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= read_data;
    end

    // Debug tag generator, frozen at zero while off
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            tag <= 8'h00;
        else if (!seq_tag)
            tag <= 8'h00;
        else if (TAG_ADVANCE)
            tag <= next_tag;
    end

    // Payload and pass-through attributes
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            payload_bytes <= PAYLOAD_MIN_BYTES;
            fwd_no_snoop <= 1'b0;
            fwd_read_size <= 3'h0;
        end
        else
        begin
            payload_bytes <= next_payload_bytes;
            fwd_no_snoop <= PASS_NO_SNOOP;
            fwd_read_size <= PASS_READ_SIZE;
        end
    end

    // Outputs
    assign PREADY = 1'b1;
    assign PSLVERR = access && !mapped;
    assign CORR_REPORT_ENABLE = ctrl.correctable_report_enable;
    assign NONFATAL_REPORT_ENABLE = ctrl.nonfatal_report_enable;
    assign FATAL_REPORT_ENABLE = ctrl.fatal_report_enable;
    assign UNSUP_REPORT_ENABLE = ctrl.unsupported_request_report_enable;
    assign RELAXED_ORDERING_ATTR = 1'b0;
    assign FWD_NO_SNOOP = fwd_no_snoop;
    assign FWD_READ_SIZE = fwd_read_size;
    assign PAYLOAD_BYTES = payload_bytes;
    assign SUPPORTED_PAYLOAD = SUPPORTED_PAYLOAD_CODE;
    assign DEBUG_SEQ_TAG = seq_tag;
    assign TAG_VALUE = tag;

    // Checks
    a_report_reset: assert property (@(posedge CLK) $fell(RST) |-> ctrl[3:0] == 4'h0)
        else $error("report enables not zero after reset");
    a_report_write: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && PSTRB[0] |=> ctrl[3:0] == $past(PWDATA[3:0]))
        else $error("report enables did not take write");
    a_readonly_zero: assert property (@(posedge CLK) disable iff (RST)
        ctrl_word[15:9] == 7'h0 && ctrl_word[4] == 1'b0)
        else $error("read-only bits not zero");
    a_ro_attr: assert property (@(posedge CLK) disable iff (RST)
        access && !PWRITE && hit_ctrl |-> PRDATA[4] == 1'b0 && !RELAXED_ORDERING_ATTR)
        else $error("relaxed ordering visible");
    a_payload_legal: assert property (@(posedge CLK) disable iff (RST)
        ##1 ctrl.payload_limit == 3'h2 && $stable(ctrl) |=> PAYLOAD_BYTES == 13'd512)
        else $error("payload decode wrong");
    a_payload_reserved: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit > 3'h5 |=> PAYLOAD_BYTES == 13'd128)
        else $error("reserved payload code not 128");
    a_tag_narrow: assert property (@(posedge CLK) disable iff (RST)
        seq_tag && !ctrl.wide_tag_enable && TAG_ADVANCE && tag == 8'd31 |=> tag == 8'd0)
        else $error("narrow tag did not wrap at 31");
    a_tag_wide: assert property (@(posedge CLK) disable iff (RST)
        seq_tag && ctrl.wide_tag_enable && TAG_ADVANCE && tag == 8'd31 |=> tag == 8'd32)
        else $error("wide tag wrapped early");
    a_tag_idle: assert property (@(posedge CLK) disable iff (RST)
        !seq_tag |=> tag == 8'h00)
        else $error("tag moves outside debug mode");
    a_pass_through: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> FWD_NO_SNOOP == $past(PASS_NO_SNOOP)
            && FWD_READ_SIZE == $past(PASS_READ_SIZE))
        else $error("pass-through attribute altered");
    a_supported_code: assert property (@(posedge CLK) SUPPORTED_PAYLOAD == 3'h4)
        else $error("supported payload code wrong");
    c_ctrl_write: cover property (@(posedge CLK) disable iff (RST) wr_ctrl);
    c_reserved_code: cover property (@(posedge CLK) disable iff (RST) ctrl.payload_limit == 3'h7);
    c_wide_wrap: cover property (@(posedge CLK) disable iff (RST)
        seq_tag && ctrl.wide_tag_enable && tag == 8'hff && TAG_ADVANCE);
    c_unmapped: cover property (@(posedge CLK) disable iff (RST) PSLVERR);

    // Report enables follow byte lane 0 of a write, one bit each
    a_corr_write: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && PSTRB[0] |=> CORR_REPORT_ENABLE == $past(PWDATA[0]))
        else $error("correctable enable did not take write");

    a_nonfatal_write: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && PSTRB[0] |=> NONFATAL_REPORT_ENABLE == $past(PWDATA[1]))
        else $error("non-fatal enable did not take write");

    a_fatal_write: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && PSTRB[0] |=> FATAL_REPORT_ENABLE == $past(PWDATA[2]))
        else $error("fatal enable did not take write");

    a_unsup_write: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && PSTRB[0] |=> UNSUP_REPORT_ENABLE == $past(PWDATA[3]))
        else $error("unsupported request enable did not take write");

    a_ctrl_hold: assert property (@(posedge CLK) disable iff (RST)
        !wr_ctrl |=> $stable(ctrl))
        else $error("control fields changed without a write");

    a_lane0_keep: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && !PSTRB[0] |=> ctrl[3:0] == $past(ctrl[3:0]))
        else $error("report enables changed with lane 0 off");

    // Relaxed ordering never shows, on the pin or in read data
    a_relaxed_attr: assert property (@(posedge CLK) disable iff (RST)
        RELAXED_ORDERING_ATTR == 1'b0)
        else $error("relaxed ordering attribute set");

    a_relaxed_read: assert property (@(posedge CLK) disable iff (RST)
        PSEL && !PENABLE && !PWRITE && hit_ctrl |=> PRDATA[4] == 1'b0)
        else $error("relaxed ordering bit read as one");

    // Payload limit storage and decode, one cycle behind the field
    a_payload_write: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && PSTRB[0] |=> ctrl.payload_limit == $past(PWDATA[7:5]))
        else $error("payload limit did not take write");

    a_payload_code0: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit == 3'h0 |=> PAYLOAD_BYTES == 13'h0080)
        else $error("payload code 0 not 128 bytes");

    a_payload_code1: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit == 3'h1 |=> PAYLOAD_BYTES == 13'h0100)
        else $error("payload code 1 not 256 bytes");

    a_payload_code2: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit == 3'h2 |=> PAYLOAD_BYTES == 13'h0200)
        else $error("payload code 2 not 512 bytes");

    a_payload_code3: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit == 3'h3 |=> PAYLOAD_BYTES == 13'h0400)
        else $error("payload code 3 not 1024 bytes");

    a_payload_code4: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit == 3'h4 |=> PAYLOAD_BYTES == 13'h0800)
        else $error("payload code 4 not 2048 bytes");

    a_payload_code5: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit == 3'h5 |=> PAYLOAD_BYTES == 13'h1000)
        else $error("payload code 5 not 4096 bytes");

    a_payload_range: assert property (@(posedge CLK) disable iff (RST)
        PAYLOAD_BYTES >= 13'h0080 && PAYLOAD_BYTES <= 13'h1000)
        else $error("payload size out of range");

    // Reserved payload codes act as the smallest size
    a_payload_code6: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit == 3'h6 |=> PAYLOAD_BYTES == 13'h0080)
        else $error("payload code 6 not 128 bytes");

    a_payload_code7: assert property (@(posedge CLK) disable iff (RST)
        ctrl.payload_limit == 3'h7 |=> PAYLOAD_BYTES == 13'h0080)
        else $error("payload code 7 not 128 bytes");

    // Wide tag enable follows byte lane 1 only
    a_wide_tag_write: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && PSTRB[1] |=> ctrl.wide_tag_enable == $past(PWDATA[8]))
        else $error("wide tag enable did not take write");

    a_wide_tag_keep: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl && !PSTRB[1] |=> ctrl.wide_tag_enable == $past(ctrl.wide_tag_enable))
        else $error("wide tag enable changed with lane 1 off");

    // Debug tag counter steps, holds and wraps
    a_tag_step: assert property (@(posedge CLK) disable iff (RST)
        seq_tag && TAG_ADVANCE && tag < 8'h1f |=> tag == 8'($past(tag) + 8'h01))
        else $error("tag did not step by one");

    a_tag_hold: assert property (@(posedge CLK) disable iff (RST)
        seq_tag && !TAG_ADVANCE |=> tag == $past(tag))
        else $error("tag moved without advance");

    a_narrow_bound: assert property (@(posedge CLK) disable iff (RST)
        seq_tag && !ctrl.wide_tag_enable && TAG_ADVANCE && tag > 8'h1f |=> tag == 8'h00)
        else $error("narrow tag left above its range");

    a_wide_wrap: assert property (@(posedge CLK) disable iff (RST)
        seq_tag && ctrl.wide_tag_enable && TAG_ADVANCE && tag == 8'hff |=> tag == 8'h00)
        else $error("wide tag did not wrap at 255");

    a_debug_write: assert property (@(posedge CLK) disable iff (RST)
        wr_debug && PSTRB[0] |=> seq_tag == $past(PWDATA[0]))
        else $error("debug tag control did not take write");

    // Hardwired fields always read zero
    a_phantom_read: assert property (@(posedge CLK) disable iff (RST)
        PSEL && !PENABLE && !PWRITE && hit_ctrl |=> PRDATA[9] == 1'b0)
        else $error("phantom function bit read as one");

    a_aux_read: assert property (@(posedge CLK) disable iff (RST)
        PSEL && !PENABLE && !PWRITE && hit_ctrl |=> PRDATA[10] == 1'b0)
        else $error("aux power bit read as one");

    a_no_snoop_read: assert property (@(posedge CLK) disable iff (RST)
        PSEL && !PENABLE && !PWRITE && hit_ctrl |=> PRDATA[11] == 1'b0)
        else $error("no-snoop bit read as one");

    a_read_size_read: assert property (@(posedge CLK) disable iff (RST)
        PSEL && !PENABLE && !PWRITE && hit_ctrl |=> PRDATA[14:12] == 3'h0)
        else $error("read request size read nonzero");

    a_upper_read: assert property (@(posedge CLK) disable iff (RST)
        PSEL && !PENABLE && !PWRITE && hit_ctrl |=> PRDATA[31:15] == 17'h00000)
        else $error("reserved bits read nonzero");

    // Unmapped accesses are refused and change nothing
    a_unmapped_error: assert property (@(posedge CLK) disable iff (RST)
        access && !mapped |-> PSLVERR)
        else $error("unmapped access not refused");

    a_mapped_ok: assert property (@(posedge CLK) disable iff (RST)
        access && mapped |-> !PSLVERR)
        else $error("mapped access refused");

    a_unmapped_keep: assert property (@(posedge CLK) disable iff (RST)
        access && PWRITE && !mapped |=> $stable(ctrl) && $stable(seq_tag))
        else $error("unmapped write changed a register");

    a_unmapped_read: assert property (@(posedge CLK) disable iff (RST)
        PSEL && !PENABLE && !PWRITE && !mapped |=> PRDATA == 32'h0000_0000)
        else $error("unmapped read nonzero");
    c_narrow_wrap: cover property (@(posedge CLK) disable iff (RST)
        seq_tag && !ctrl.wide_tag_enable && tag == 8'h1f && TAG_ADVANCE);

endmodule : dcr_device_control

//--- dv/pcie_device_control_register_test.sv
// Self-checking bench for the device control register block, driven over APB.
// Assumes the design package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module pcie_device_control_register_test
    import dcr_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, tag_advance, pass_no_snoop, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [2:0] pass_read_size, fwd_rs, sup_payload;
    logic pready, pslverr, corr_en, nf_en, fatal_en, unsup_en, ro_attr, fwd_ns, dbg_tag;
    logic [12:0] payload_bytes;
    logic [7:0] tag_value;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    dcr_device_control u_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TAG_ADVANCE(tag_advance),
        .PASS_NO_SNOOP(pass_no_snoop), .PASS_READ_SIZE(pass_read_size),
        .CORR_REPORT_ENABLE(corr_en), .NONFATAL_REPORT_ENABLE(nf_en),
        .FATAL_REPORT_ENABLE(fatal_en), .UNSUP_REPORT_ENABLE(unsup_en),
        .RELAXED_ORDERING_ATTR(ro_attr), .FWD_NO_SNOOP(fwd_ns), .FWD_READ_SIZE(fwd_rs),
        .PAYLOAD_BYTES(payload_bytes), .SUPPORTED_PAYLOAD(sup_payload),
        .DEBUG_SEQ_TAG(dbg_tag), .TAG_VALUE(tag_value));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles >= 5000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_reset;
        apb(1'b0, DEVICE_CONTROL_OFFSET, 32'h0);
        check(rd, 32'h0);
        check({19'h0, payload_bytes}, 32'h80);
        check({29'h0, sup_payload}, 32'h4);
        check({28'h0, corr_en, nf_en, fatal_en, unsup_en}, 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_fields;
        apb(1'b1, DEVICE_CONTROL_OFFSET, 32'hffffffff);
        apb(1'b0, DEVICE_CONTROL_OFFSET, 32'h0);
        check(rd, 32'h1ef);
        check({28'h0, corr_en, nf_en, fatal_en, unsup_en}, 32'hf);
        check({31'h0, ro_attr}, 32'h0);
        apb(1'b1, DEVICE_CONTROL_OFFSET, 32'h5);
        #1;
        check({28'h0, corr_en, nf_en, fatal_en, unsup_en}, 32'ha);
        $display("field test done");
    endtask : t_fields

    // Every payload code, reserved ones included
    task automatic t_payload;
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, DEVICE_CONTROL_OFFSET, 32'(c) << 5);
            @(posedge clk);
            #1;
            check({19'h0, payload_bytes}, (c <= 5) ? (32'h80 << c) : 32'h80);
            apb(1'b0, DEVICE_CONTROL_OFFSET, 32'h0);
            check(rd, 32'(c) << 5);
        end
        $display("payload test done");
    endtask : t_payload

    // Unmapped access is refused and leaves the register alone
    task automatic t_unmapped;
        apb(1'b1, 12'h0c0, 32'hffff);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 12'h0c0, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, DEVICE_CONTROL_OFFSET, 32'h0);
        check({err, rd[30:0]}, 32'he0);
        $display("unmapped test done");
    endtask : t_unmapped

    task automatic t_pass;
        for (int v = 0; v < 16; v++)
        begin
            @(posedge clk);
            pass_no_snoop <= v[3];
            pass_read_size <= v[2:0];
            @(posedge clk);
            #1;
            check({28'h0, fwd_ns, fwd_rs}, 32'(v));
        end
        $display("pass-through test done");
    endtask : t_pass

    // Advance the tag n cycles, then compare
    task automatic adv(input int n, input logic [7:0] exp);
        @(posedge clk);
        tag_advance <= 1'b1;
        repeat (n) @(posedge clk);
        tag_advance <= 1'b0;
        #1;
        check({24'h0, tag_value}, {24'h0, exp});
    endtask : adv

    task automatic t_tag;
        adv(4, 8'h0);
        apb(1'b1, DEBUG_CONTROL_OFFSET, 32'h1);
        #1;
        check({31'h0, dbg_tag}, 32'h1);
        adv(31, 8'h1f);
        adv(1, 8'h0);
        apb(1'b1, DEVICE_CONTROL_OFFSET, 32'h100);
        adv(255, 8'hff);
        adv(1, 8'h0);
        apb(1'b1, DEBUG_CONTROL_OFFSET, 32'h0);
        $display("tag test done");
    endtask : t_tag

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial
    begin
        {rst, psel, penable, pwrite, tag_advance, pass_no_snoop} = 6'h20;
        {paddr, pwdata, pass_read_size} = '0;
        pstrb = 4'h3;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_payload();
        t_unmapped();
        t_pass();
        t_tag();
        tally_and_finish();
    end
endmodule : pcie_device_control_register_test
